// >>> pkg/scpt_pkg.sv
// Shared constants for the sampling clock and timestamp control block
package scpt_pkg;
   localparam int PIN_N = 9;
   // Register offsets
   localparam logic [11:0] REG_NOISE = 12'h02B;
   localparam logic [11:0] REG_DIV = 12'h03D;
   localparam logic [11:0] REG_NDIV = 12'h03E;
   localparam logic [11:0] REG_RST = 12'h05C;
   localparam logic [11:0] REG_CALEN = 12'h05D;
   localparam logic [11:0] REG_CALDONE = 12'h05E;
   localparam logic [11:0] REG_TRIG = 12'h060;
   localparam logic [11:0] REG_MARK = 12'h061;
   localparam logic [11:0] REG_RXDIV = 12'h062;
   localparam logic [11:0] REG_SYSWIN = 12'h063;
   localparam logic [11:0] REG_LOCK = 12'h208;
   localparam int DIV_P_LSB = 4;
   localparam int DIV_V_LSB = 0;
   localparam int TRIG_EN_BIT = 0;
   localparam int TRIG_SRC_BIT = 1;
   localparam int TRIG_MODE_LSB = 2;
   localparam logic [1:0] TRIG_MODE_MARKER = 2'h3;
   localparam int MARK_RECV_BIT = 0;
   localparam int MARK_INS_BIT = 1;
   localparam int PIN_PLLEN = 0;
   localparam int PIN_REFSEL = 1;
   localparam int PIN_PD = 2;
   localparam int PIN_CFG0 = 3;
   localparam int PIN_CFG1 = 4;
   localparam int PIN_MARK = 5;
   localparam int PIN_DIFF = 6;
   localparam int PIN_SE = 7;
   localparam int PIN_SYSREF = 8;
   // Reset values
   localparam logic [7:0] RST_NOISE = 8'h00;
   localparam logic [7:0] RST_DIV = 8'h15;
   localparam logic [7:0] RST_NDIV = 8'h08;
   localparam logic [7:0] RST_PLLRST = 8'h01;
   localparam logic [7:0] RST_CALEN = 8'h00;
   localparam logic [7:0] RST_TRIG = 8'h00;
   localparam logic [7:0] RST_MARK = 8'h00;
   localparam logic [7:0] RST_RXDIV = 8'h04;
   // Timing
   localparam logic [9:0] CAL_CNT = 10'h0FA;
   localparam logic [9:0] LOCK_CNT = 10'h064;
endpackage

// >>> pkg/scpt_if.sv
// Link between the clock control device and its configuring host
`timescale 1ns/1ns
interface scpt_if;
   logic [11:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic pll_en_pin;
   logic ref_select_pin;
   logic power_down_pin;
   logic [1:0] aux_clock_config_pins;
   modport dev (
      input reg_addr, reg_wdata, reg_wr, reg_rd, pll_en_pin, ref_select_pin,
      input power_down_pin, aux_clock_config_pins,
      output reg_rdata
   );
   modport host (
      output reg_addr, reg_wdata, reg_wr, reg_rd, pll_en_pin, ref_select_pin,
      output power_down_pin, aux_clock_config_pins,
      input reg_rdata
   );
endinterface

// >>> core/scpt_divider.sv
// Enable-pulse divider: one pulse every divisor ticks
`timescale 1ns/1ns
module scpt_divider
   import scpt_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic tick,
   input wire logic [7:0] divisor,
   output logic pulse
);
   logic [7:0] cnt_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= 8'h00;
         pulse <= 1'b0;
      end else begin
         pulse <= 1'b0;
         if (tick) begin
            // Divisor of zero behaves as one
            if (cnt_reg + 8'h01 >= divisor) begin
               cnt_reg <= 8'h00;
               pulse <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + 8'h01;
            end
         end
      end
   end
endmodule // scpt_divider

// >>> core/scpt_device.sv
// Sampling clock, converter PLL sequencing and timestamp path of the converter
// What this block and its host must do
// R1: Retimed marker repeated on trigger when mode 3
// R2: Insertion enable puts marker in sample LSB
// R3: 12-bit word: marker bit 0, data 11:1
// R4: Marker sampled with data, matched latency
// R5: Host enables marker receiver before use
// R6: PLL pin selects PLL; ref select picks reference
// R7: Both pins low: direct differential clock
// R8: Single-ended input unusable without PLL
// R9: Reference forwarded only with PLL; aux copies
// R10: Clock outputs live only with PLL enabled and power-down low
// R11: SerDes clock from sampling clock, divided out
// R12: SYSREF captured by clock, window measured
// R13: Selected clock drives cores and SerDes
// R14: PLL locks when VCO/(V*P*N) equals reference
// R15: Host uses only supported divisor products
// R16: Unsupported rate: disable PLL, direct clock
// R17: Host holds PLL reset while reconfiguring
// R18: Host programs dividers while in reset
// R19: Calibration runs on reset release if enabled
// R20: Done and locked flags readable
// R21: Noise suppression control register
// R22: Trigger output disabled until host enables
// R23: SerDes source gives line rate over divider
// R24: Host polls done and lock before use
`timescale 1ns/1ns
module scpt_device
   import scpt_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   scpt_if.dev link,
   input wire logic marker_input,
   input wire logic diff_clk_in,
   input wire logic single_ended_ref_input,
   input wire logic sysref_in,
   input wire logic [11:0] adc_sample,
   output logic [11:0] link_sample,
   output logic link_valid,
   output logic trigger_output,
   output logic ref_clock_lvds_out,
   output logic aux_clock_out_c,
   output logic aux_clock_out_d,
   output logic [7:0] noise_suppress,
   output logic sysref_captured
);
   typedef enum {CAL_IDLE, CAL_RUN, CAL_LOCKING, CAL_READY} scpt_cal_type;

   logic [PIN_N-1:0] raw_pins;
   logic [PIN_N-1:0] s1_reg, s2_reg, s3_reg, pin_reg;
   logic [7:0] div_reg, ndiv_reg, pllrst_reg, calen_reg, trig_reg, mark_reg;
   logic [7:0] rxdiv_reg, syswin_reg, rdata_reg;
   logic [9:0] cnt_reg;
   scpt_cal_type cal_reg;
   logic cal_done_reg, locked_reg, pllrst_prev_reg;
   logic diff_prev_reg, ref_prev_reg, sys_prev_reg;
   logic ref_half_reg, serdes_tgl_reg;
   logic [1:0] ref_quarter_reg;
   logic [7:0] win_cnt_reg;
   logic win_open_reg;
   logic pll_en, ref_sel, pd, ref_clk, ref_rise, diff_rise, sys_rise;
   logic pll_pulse, sample_tick, serdes_pulse;
   logic [7:0] vp_product;

   function automatic logic vp_supported(input logic [7:0] vp);
      case (vp)
         8'h05, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h10: vp_supported = 1'b1;
         default: vp_supported = 1'b0;
      endcase
   endfunction

   assign raw_pins = {sysref_in, single_ended_ref_input, diff_clk_in, marker_input,
                      link.aux_clock_config_pins, link.power_down_pin,
                      link.ref_select_pin, link.pll_en_pin};

   // Board pins are asynchronous; accept a change once stages two and three agree
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s1_reg <= 9'h000;
         s2_reg <= 9'h000;
         s3_reg <= 9'h000;
         pin_reg <= 9'h000;
      end else begin
         s1_reg <= raw_pins;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         pin_reg <= (s2_reg & s3_reg) | (pin_reg & (s2_reg | s3_reg));
      end
   end

   assign pll_en = pin_reg[PIN_PLLEN];
   assign ref_sel = pin_reg[PIN_REFSEL];
   assign pd = pin_reg[PIN_PD];
   assign ref_clk = ref_sel ? pin_reg[PIN_SE] : pin_reg[PIN_DIFF]; // see R6
   assign ref_rise = ref_clk && !ref_prev_reg;
   assign diff_rise = pin_reg[PIN_DIFF] && !diff_prev_reg;
   assign sys_rise = pin_reg[PIN_SYSREF] && !sys_prev_reg;
   assign vp_product = 8'(div_reg[DIV_P_LSB +: 4] * div_reg[DIV_V_LSB +: 4]);

   // Register writes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         noise_suppress <= RST_NOISE;
         div_reg <= RST_DIV;
         ndiv_reg <= RST_NDIV;
         pllrst_reg <= RST_PLLRST;
         calen_reg <= RST_CALEN;
         trig_reg <= RST_TRIG; // see R22
         mark_reg <= RST_MARK;
         rxdiv_reg <= RST_RXDIV;
      end else if (link.reg_wr) begin
         case (link.reg_addr)
            REG_NOISE: noise_suppress <= link.reg_wdata; // see R21
            REG_DIV: div_reg <= link.reg_wdata;
            REG_NDIV: ndiv_reg <= link.reg_wdata;
            REG_RST: pllrst_reg <= link.reg_wdata;
            REG_CALEN: calen_reg <= link.reg_wdata;
            REG_TRIG: trig_reg <= link.reg_wdata;
            REG_MARK: mark_reg <= link.reg_wdata;
            REG_RXDIV: rxdiv_reg <= link.reg_wdata;
            default: ;
         endcase
      end
   end

   // Read data one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= 8'h00;
      end else if (link.reg_rd) begin
         case (link.reg_addr)
            REG_NOISE: rdata_reg <= noise_suppress;
            REG_DIV: rdata_reg <= div_reg;
            REG_NDIV: rdata_reg <= ndiv_reg;
            REG_RST: rdata_reg <= pllrst_reg;
            REG_CALEN: rdata_reg <= calen_reg;
            REG_CALDONE: rdata_reg <= {7'h00, cal_done_reg}; // see R20
            REG_TRIG: rdata_reg <= trig_reg;
            REG_MARK: rdata_reg <= mark_reg;
            REG_RXDIV: rdata_reg <= rxdiv_reg;
            REG_SYSWIN: rdata_reg <= syswin_reg;
            REG_LOCK: rdata_reg <= {7'h00, locked_reg}; // see R20
            default: rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end
   assign link.reg_rdata = rdata_reg;

   // Calibration and lock; any reset of the PLL drops both flags
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cal_reg <= CAL_IDLE;
         cnt_reg <= 10'h000;
         cal_done_reg <= 1'b0;
         locked_reg <= 1'b0;
         pllrst_prev_reg <= 1'b1;
      end else begin
         pllrst_prev_reg <= pllrst_reg[0];
         if (pllrst_reg[0] || !pll_en) begin
            cal_reg <= CAL_IDLE;
            cal_done_reg <= 1'b0;
            locked_reg <= 1'b0;
         end else begin
            case (cal_reg)
               CAL_IDLE: begin
                  if (pllrst_prev_reg && calen_reg[0]) begin // see R19
                     cal_reg <= CAL_RUN;
                     cnt_reg <= CAL_CNT;
                  end
               end
               CAL_RUN: begin
                  if (cnt_reg == 10'h001) begin
                     cal_done_reg <= 1'b1;
                     cnt_reg <= LOCK_CNT;
                     cal_reg <= CAL_LOCKING;
                  end else begin
                     cnt_reg <= cnt_reg - 10'h001;
                  end
               end
               CAL_LOCKING: begin
                  // Unsupported divisor never locks; loop cannot close
                  if (cnt_reg == 10'h001) begin
                     locked_reg <= vp_supported(vp_product) && (ndiv_reg != 8'h00); // see R14
                     cal_reg <= CAL_READY;
                  end else begin
                     cnt_reg <= cnt_reg - 10'h001;
                  end
               end
               CAL_READY: ;
               default: cal_reg <= CAL_IDLE;
            endcase
         end
      end
   end

   // VCO modelled by the system clock, divided by V times P
   scpt_divider u_pll_div (
      .clk(clk),
      .resetn(resetn),
      .tick(locked_reg),
      .divisor(vp_product),
      .pulse(pll_pulse)
   );

   // PLL pulse, else direct clock; SE alone gives none
   assign sample_tick = pll_en ? pll_pulse : (!ref_sel && diff_rise); // see R6, R7, R8, R13

   // SerDes clock follows the sampling clock, then the receive divider
   scpt_divider u_serdes_div (
      .clk(clk),
      .resetn(resetn),
      .tick(sample_tick),
      .divisor(rxdiv_reg),
      .pulse(serdes_pulse)
   );

   // Marker captured in place of converter bit 0 on the same tick as data
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         link_sample <= 12'h000;
         link_valid <= 1'b0;
      end else begin
         link_valid <= sample_tick;
         if (sample_tick) begin
            if (mark_reg[MARK_INS_BIT] && mark_reg[MARK_RECV_BIT]) begin // see R2, R5
               link_sample <= {adc_sample[11:1], pin_reg[PIN_MARK]}; // see R3, R4
            end else begin
               link_sample <= adc_sample;
            end
         end
      end
   end

   // Trigger output: retimed marker or divided SerDes clock
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         serdes_tgl_reg <= 1'b0;
         trigger_output <= 1'b0;
      end else begin
         if (serdes_pulse) begin
            serdes_tgl_reg <= !serdes_tgl_reg; // see R11, R23
         end
         if (!trig_reg[TRIG_EN_BIT]) begin
            trigger_output <= 1'b0; // see R22
         end else if (trig_reg[TRIG_SRC_BIT]) begin
            trigger_output <= serdes_tgl_reg; // see R23
         end else if (trig_reg[TRIG_MODE_LSB +: 2] == TRIG_MODE_MARKER) begin
            if (sample_tick) begin
               trigger_output <= pin_reg[PIN_MARK] && mark_reg[MARK_RECV_BIT]; // see R1
            end
         end else begin
            trigger_output <= 1'b0;
         end
      end
   end

   // Reference and auxiliary clock outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ref_prev_reg <= 1'b0;
         diff_prev_reg <= 1'b0;
         ref_half_reg <= 1'b0;
         ref_quarter_reg <= 2'h0;
         ref_clock_lvds_out <= 1'b0;
         aux_clock_out_c <= 1'b0;
         aux_clock_out_d <= 1'b0;
      end else begin
         ref_prev_reg <= ref_clk;
         diff_prev_reg <= pin_reg[PIN_DIFF];
         if (ref_rise) begin
            ref_half_reg <= !ref_half_reg;
            ref_quarter_reg <= ref_quarter_reg + 2'h1;
         end
         ref_clock_lvds_out <= pll_en && !pd && ref_clk; // see R9, R10
         if (pd || !pll_en) begin
            aux_clock_out_c <= 1'b0; // see R10
            aux_clock_out_d <= 1'b0;
         end else begin
            case (pin_reg[PIN_CFG1:PIN_CFG0]) // see R9
               2'h1: aux_clock_out_c <= ref_clk;
               2'h2: aux_clock_out_c <= ref_half_reg;
               2'h3: aux_clock_out_c <= ref_quarter_reg[1];
               default: aux_clock_out_c <= 1'b0;
            endcase
            // Output d only runs while c is enabled and is never divided
            aux_clock_out_d <= (|pin_reg[PIN_CFG1:PIN_CFG0]) && ref_clk;
         end
      end
   end

   // SYSREF: capture on sampling clock; window counts edge to next tick
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sys_prev_reg <= 1'b0;
         sysref_captured <= 1'b0;
         win_open_reg <= 1'b0;
         win_cnt_reg <= 8'h00;
         syswin_reg <= 8'h00;
      end else begin
         sys_prev_reg <= pin_reg[PIN_SYSREF];
         if (sample_tick) begin
            sysref_captured <= pin_reg[PIN_SYSREF]; // see R12
         end
         if (sys_rise) begin
            win_open_reg <= 1'b1;
            win_cnt_reg <= 8'h00;
         end else if (win_open_reg) begin
            if (sample_tick) begin
               win_open_reg <= 1'b0;
               syswin_reg <= win_cnt_reg; // see R12
            end else if (win_cnt_reg != 8'hFF) begin
               win_cnt_reg <= win_cnt_reg + 8'h01;
            end
         end
      end
   end
endmodule // scpt_device

// >>> core/scpt_host.sv
// Host end: drives straps and runs the PLL bring-up sequence
`timescale 1ns/1ns
module scpt_host
   import scpt_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   scpt_if.host link,
   input wire logic [2:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   output logic [7:0] cmd_rdata
);
   typedef enum {S_IDLE, S_RST, S_DIV, S_NDIV, S_CAL, S_MARK, S_TRIG, S_REL,
                 S_RD_DONE, S_WT_DONE, S_CHK_DONE, S_RD_LOCK, S_WT_LOCK,
                 S_CHK_LOCK} scpt_seq_type;

   localparam logic [2:0] CMD_CTRL = 3'h0;
   localparam logic [2:0] CMD_DIV = 3'h1;
   localparam logic [2:0] CMD_NDIV = 3'h2;
   localparam logic [2:0] CMD_MARK = 3'h3;
   localparam logic [2:0] CMD_TRIG = 3'h4;
   localparam logic [2:0] CMD_STAT = 3'h5;

   scpt_seq_type st_reg;
   logic [7:0] ctrl_reg, div_reg, ndiv_reg, mark_reg, trig_reg;
   logic ready_reg;

   assign link.pll_en_pin = ctrl_reg[1];
   assign link.ref_select_pin = ctrl_reg[2];
   assign link.power_down_pin = ctrl_reg[3];
   assign link.aux_clock_config_pins = ctrl_reg[5:4];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg <= 8'h00;
         div_reg <= RST_DIV;
         ndiv_reg <= RST_NDIV;
         mark_reg <= RST_MARK;
         trig_reg <= RST_TRIG;
         cmd_rdata <= 8'h00;
      end else begin
         cmd_rdata <= 8'h00;
         if (cmd_wr) begin
            case (cmd_addr)
               CMD_CTRL: ctrl_reg <= cmd_wdata;
               CMD_DIV: div_reg <= cmd_wdata;
               CMD_NDIV: ndiv_reg <= cmd_wdata;
               CMD_MARK: mark_reg <= cmd_wdata;
               CMD_TRIG: trig_reg <= cmd_wdata;
               default: ;
            endcase
         end else begin
            ctrl_reg[0] <= 1'b0;
         end
         if (cmd_rd) begin
            case (cmd_addr)
               CMD_CTRL: cmd_rdata <= ctrl_reg;
               CMD_DIV: cmd_rdata <= div_reg;
               CMD_NDIV: cmd_rdata <= ndiv_reg;
               CMD_MARK: cmd_rdata <= mark_reg;
               CMD_TRIG: cmd_rdata <= trig_reg;
               CMD_STAT: cmd_rdata <= {6'h00, st_reg != S_IDLE, ready_reg};
               default: cmd_rdata <= 8'h00;
            endcase
         end
      end
   end

   // One device access per state; reads land one cycle later
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_reg <= S_IDLE;
         ready_reg <= 1'b0;
         link.reg_addr <= 12'h000;
         link.reg_wdata <= 8'h00;
         link.reg_wr <= 1'b0;
         link.reg_rd <= 1'b0;
      end else begin
         link.reg_wr <= 1'b0;
         link.reg_rd <= 1'b0;
         case (st_reg)
            S_IDLE: begin
               if (ctrl_reg[0]) begin
                  ready_reg <= 1'b0;
                  st_reg <= S_RST;
               end
            end
            S_RST: begin
               link.reg_addr <= REG_RST; // see R17
               link.reg_wdata <= 8'h01;
               link.reg_wr <= 1'b1;
               st_reg <= S_DIV;
            end
            S_DIV: begin
               link.reg_addr <= REG_DIV; // see R18, R15
               link.reg_wdata <= div_reg;
               link.reg_wr <= 1'b1;
               st_reg <= S_NDIV;
            end
            S_NDIV: begin
               link.reg_addr <= REG_NDIV; // see R18
               link.reg_wdata <= ndiv_reg;
               link.reg_wr <= 1'b1;
               st_reg <= S_CAL;
            end
            S_CAL: begin
               link.reg_addr <= REG_CALEN; // see R19
               link.reg_wdata <= 8'h01;
               link.reg_wr <= 1'b1;
               st_reg <= S_MARK;
            end
            S_MARK: begin
               link.reg_addr <= REG_MARK; // see R5
               link.reg_wdata <= mark_reg;
               link.reg_wr <= 1'b1;
               st_reg <= S_TRIG;
            end
            S_TRIG: begin
               link.reg_addr <= REG_TRIG; // see R22
               link.reg_wdata <= trig_reg;
               link.reg_wr <= 1'b1;
               st_reg <= S_REL;
            end
            S_REL: begin
               link.reg_addr <= REG_RST; // see R19
               link.reg_wdata <= 8'h00;
               link.reg_wr <= 1'b1;
               st_reg <= S_RD_DONE;
            end
            S_RD_DONE: begin
               link.reg_addr <= REG_CALDONE;
               link.reg_rd <= 1'b1;
               st_reg <= S_WT_DONE;
            end
            S_WT_DONE: st_reg <= S_CHK_DONE;
            S_CHK_DONE: begin
               // Poll has no timeout; software reads busy to spot a hang
               st_reg <= link.reg_rdata[0] ? S_RD_LOCK : S_RD_DONE; // see R24
            end
            S_RD_LOCK: begin
               link.reg_addr <= REG_LOCK;
               link.reg_rd <= 1'b1;
               st_reg <= S_WT_LOCK;
            end
            S_WT_LOCK: st_reg <= S_CHK_LOCK;
            S_CHK_LOCK: begin
               if (link.reg_rdata[0]) begin
                  ready_reg <= 1'b1; // see R24
                  st_reg <= S_IDLE;
               end else begin
                  st_reg <= S_RD_LOCK;
               end
            end
            default: st_reg <= S_IDLE;
         endcase
      end
   end
endmodule // scpt_host

// >>> verif/scpt_asserts.sv
// Protocol checks on the host to device register link
`timescale 1ns/1ns
module scpt_asserts
   import scpt_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic pll_en_pin,
   input wire logic ref_select_pin,
   input wire logic power_down_pin,
   input wire logic [1:0] aux_clock_config_pins
);
   logic in_rst_reg, cal_en_reg, last_rd_reg, done_seen_reg;
   logic [9:0] rel_cnt_reg;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Link-side mirror of PLL state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         in_rst_reg <= 1'b1;
         cal_en_reg <= 1'b0;
         last_rd_reg <= 1'b0;
         done_seen_reg <= 1'b0;
         rel_cnt_reg <= 10'h000;
      end else begin
         last_rd_reg <= reg_rd && reg_addr == REG_CALDONE;
         if (reg_wr && reg_addr == REG_RST) in_rst_reg <= reg_wdata[0];
         if (reg_wr && reg_addr == REG_CALEN) cal_en_reg <= reg_wdata[0];
         if (reg_wr && reg_addr == REG_RST && reg_wdata[0]) done_seen_reg <= 1'b0;
         else if (last_rd_reg && reg_rdata == 8'h01) done_seen_reg <= 1'b1;
         if (reg_wr && reg_addr == REG_RST && !reg_wdata[0]) rel_cnt_reg <= 10'h000;
         else if (rel_cnt_reg != 10'h3FF) rel_cnt_reg <= rel_cnt_reg + 10'h001;
      end
   end
   rd_idle_zero_a: assert property (
      !reg_rd |=> reg_rdata == 8'h00) else $error("stray read data");
   div_in_reset_a: assert property (
      reg_wr && (reg_addr == REG_DIV || reg_addr == REG_NDIV) |-> in_rst_reg)
      else $error("divider out of reset");
   calen_in_reset_a: assert property (
      reg_wr && reg_addr == REG_CALEN |-> in_rst_reg) else $error("cal enable out of reset");
   cal_before_rel_a: assert property (
      reg_wr && reg_addr == REG_RST && !reg_wdata[0] |-> cal_en_reg)
      else $error("release without cal");
   done_early_a: assert property (
      reg_rd && reg_addr == REG_CALDONE && (in_rst_reg || rel_cnt_reg < 10'd240)
      |=> reg_rdata == 8'h00) else $error("done too early");
   done_late_a: assert property (
      reg_rd && reg_addr == REG_CALDONE && !in_rst_reg && cal_en_reg && pll_en_pin
      && rel_cnt_reg > 10'd262 |=> reg_rdata == 8'h01) else $error("done missing");
   lock_early_a: assert property (
      reg_rd && reg_addr == REG_LOCK && (in_rst_reg || rel_cnt_reg < 10'd340)
      |=> reg_rdata == 8'h00) else $error("lock too early");
   lock_after_done_a: assert property (
      reg_rd && reg_addr == REG_LOCK |-> done_seen_reg) else $error("lock before done");
endmodule // scpt_asserts

// >>> verif/test_sampling_clock_pll_timestamp_ctrl.sv
// Bench joining device and host ends over the register link
`timescale 1ns/1ns
module test_sampling_clock_pll_timestamp_ctrl;
   import scpt_pkg::*;
   logic clk, resetn, marker, dclk, seclk, sysref, wr, rd, lvalid, trig, lvds, auxc, auxd, scap;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, nsup;
   logic [11:0] adc, lsamp;
   int bad_count, cmp_count, cyc, n;
   scpt_if link_bus ();
   scpt_device u_scpt_device (.clk(clk), .resetn(resetn), .link(link_bus.dev),
      .marker_input(marker), .diff_clk_in(dclk), .single_ended_ref_input(seclk),
      .sysref_in(sysref), .adc_sample(adc), .link_sample(lsamp), .link_valid(lvalid),
      .trigger_output(trig), .ref_clock_lvds_out(lvds), .aux_clock_out_c(auxc),
      .aux_clock_out_d(auxd), .noise_suppress(nsup), .sysref_captured(scap));
   scpt_host u_scpt_host (.clk(clk), .resetn(resetn), .link(link_bus.host), .cmd_addr(addr),
      .cmd_wdata(wdata), .cmd_wr(wr), .cmd_rd(rd), .cmd_rdata(rdata));
   scpt_asserts u_scpt_asserts (.clk(clk), .resetn(resetn), .reg_addr(link_bus.reg_addr),
      .reg_wdata(link_bus.reg_wdata), .reg_wr(link_bus.reg_wr), .reg_rd(link_bus.reg_rd),
      .reg_rdata(link_bus.reg_rdata), .pll_en_pin(link_bus.pll_en_pin),
      .ref_select_pin(link_bus.ref_select_pin), .power_down_pin(link_bus.power_down_pin),
      .aux_clock_config_pins(link_bus.aux_clock_config_pins));
   task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic cmd(logic [2:0] a, logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic status(output logic [7:0] r);
      @(posedge clk);
      addr <= 3'h5;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      r = rdata;
      @(posedge clk);
   endtask
   task automatic settle(int k);
      repeat (k) @(negedge clk);
   endtask
   // Bounded wait; n = cycles to next strobe
   task automatic next_valid();
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (lvalid !== 1'b1 && n < 60);
      @(posedge clk);
   endtask
   task automatic bring_up(logic [7:0] mk, logic [7:0] tg);
      logic [7:0] s;
      cmd(3'h1, 8'h15);
      cmd(3'h2, 8'h08);
      cmd(3'h3, mk);
      cmd(3'h4, tg);
      cmd(3'h0, 8'h03);
      s = 8'h00;
      for (int i = 0; i < 300 && s !== 8'h01; i++) status(s);
      chk("status", 12'h001, {4'h0, s});
   endtask
   // Marker on trigger, no insertion, tick every P*V = 5 cycles
   task automatic test_pll_marker();
      bring_up(8'h01, 8'h0D);
      adc <= 12'hA5B;
      marker <= 1'b1;
      settle(10);
      next_valid();
      chk("sample", 12'hA5B, lsamp);
      chk("trigger high", 12'h001, {11'h0, trig});
      next_valid();
      chk("tick spacing", 12'h005, 12'(n));
      marker <= 1'b0;
      settle(12);
      chk("trigger low", 12'h000, {11'h0, trig});
   endtask
   // Marker in sample LSB; SerDes clock on trigger
   task automatic test_insert_serdes();
      logic t;
      bring_up(8'h03, 8'h03);
      adc <= 12'hFFF;
      settle(12);
      next_valid();
      chk("sample lsb 0", 12'hFFE, lsamp);
      adc <= 12'h800;
      marker <= 1'b1;
      settle(12);
      next_valid();
      chk("sample lsb 1", 12'h801, lsamp);
      for (int k = 0; k < 2; k++) begin
         t = trig;
         for (n = 0; n < 40 && trig === t; n++) @(negedge clk);
      end
      chk("serdes half period", 12'h014, 12'(n));
      @(posedge clk);
      marker <= 1'b0;
   endtask
   task automatic test_clock_outs();
      cmd(3'h0, 8'h12);
      dclk <= 1'b1;
      settle(10);
      chk("clock outs on", 12'h007, {9'h0, lvds, auxc, auxd});
      cmd(3'h0, 8'h1A);
      settle(10);
      chk("clock outs pd", 12'h000, {9'h0, lvds, auxc, auxd});
   endtask
   task automatic count_ticks();
      n = 0;
      for (int i = 0; i < 72; i++) begin
         @(posedge clk);
         if (i % 4 == 0 && i < 64) dclk <= ~dclk;
         @(negedge clk);
         n += (lvalid === 1'b1);
      end
   endtask
   task automatic test_bypass();
      cmd(3'h0, 8'h00);
      dclk <= 1'b0;
      sysref <= 1'b1;
      settle(10);
      count_ticks();
      chk("direct ticks", 12'h008, 12'(n));
      chk("lvds off", 12'h000, {11'h0, lvds});
      chk("sysref", 12'h001, {11'h0, scap});
      chk("noise", 12'h000, {4'h0, nsup});
      cmd(3'h0, 8'h04);
      settle(10);
      count_ticks();
      chk("se no pll ticks", 12'h000, 12'(n));
   endtask
   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Far above the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      {resetn, marker, dclk, seclk, sysref, wr, rd} = 7'h00;
      addr = 3'h0;
      wdata = 8'h00;
      adc = 12'h000;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      test_pll_marker();
      test_insert_serdes();
      test_clock_outs();
      test_bypass();
      wrap_up();
   end
endmodule // test_sampling_clock_pll_timestamp_ctrl
